// ---- shared/nvsc_defs.vh ----
// Purpose: constants for the shadowed memory host controller
// Assumes: 100 MHz system clock, period 10 ns
// Notes:   timing figures in ns, save cycle in ms; cycle counts derived from them
`ifndef NVSC_DEFS_VH
`define NVSC_DEFS_VH

`define NVSC_CLK_PERIOD_NS      10
`define NVSC_ADDR_W             6
`define NVSC_DATA_W             4
`define NVSC_WORDS              64

`define NVSC_ADDRESS_SETUP_NS   50
`define NVSC_WRITE_PULSE_MIN_NS 150
`define NVSC_WRITE_RECOVERY_NS  25
`define NVSC_READ_ACCESS_NS     300
`define NVSC_OUT_DISABLE_NS     100
`define NVSC_RESTORE_PULSE_MIN_NS    300
`define NVSC_RESTORE_CYCLE_MIN_NS    1400
`define NVSC_RESTORE_FIRST_ACCESS_NS 1100
`define NVSC_SAVE_PULSE_MIN_NS  200
`define NVSC_SAVE_CYCLE_MS      10

// least times rounded up to whole cycles
`define NVSC_CYC(ns) (((ns) + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
`define NVSC_CYC_SETUP      `NVSC_CYC(`NVSC_ADDRESS_SETUP_NS)
`define NVSC_CYC_WPULSE     `NVSC_CYC(`NVSC_WRITE_PULSE_MIN_NS)
`define NVSC_CYC_WREC       `NVSC_CYC(`NVSC_WRITE_RECOVERY_NS)
`define NVSC_CYC_RACCESS    `NVSC_CYC(`NVSC_READ_ACCESS_NS)
`define NVSC_CYC_ODIS       `NVSC_CYC(`NVSC_OUT_DISABLE_NS)
`define NVSC_CYC_RPULSE     `NVSC_CYC(`NVSC_RESTORE_PULSE_MIN_NS)
`define NVSC_CYC_RCYCLE     `NVSC_CYC(`NVSC_RESTORE_CYCLE_MIN_NS)
`define NVSC_CYC_RFIRST     `NVSC_CYC(`NVSC_RESTORE_FIRST_ACCESS_NS)
`define NVSC_CYC_SPULSE     `NVSC_CYC(`NVSC_SAVE_PULSE_MIN_NS)
`define NVSC_CYC_SCYCLE     (`NVSC_SAVE_CYCLE_MS * 1000000 / `NVSC_CLK_PERIOD_NS)

`define NVSC_CNT_W          24
`define NVSC_CMD_READ       2'h0
`define NVSC_CMD_WRITE      2'h1
`define NVSC_CMD_RESTORE    2'h2
`define NVSC_CMD_SAVE       2'h3

`endif

// ---- logic/nvsc_sync.v ----
// Purpose: two flop synchroniser for pin inputs
// Assumes: one clock domain
// Notes:   first stage is read by the second only
`timescale 1ns/100ps
module nvsc_sync #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] meta_q;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= {W{1'b0}};
            q_o    <= {W{1'b0}};
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

// ---- logic/nvsc_host.v ----
// Purpose: host controller driving the pins of a shadowed 64 x 4 memory
// Assumes: device pins are asynchronous; this block times them in cycles
// Notes:   one command at a time; CMD_READY_O low while a command runs
`timescale 1ns/100ps
`include "nvsc_defs.vh"
module nvsc_host #(
    parameter SAVE_CYCLES = `NVSC_CYC_SCYCLE
) (
    input  wire                    SYS_CLK_I,
    input  wire                    RESET_I,
    input  wire                    CMD_VALID_I,
    input  wire [1:0]              CMD_OP_I,
    input  wire [`NVSC_ADDR_W-1:0] CMD_ADDR_I,
    input  wire [`NVSC_DATA_W-1:0] CMD_WDATA_I,
    input  wire                    POWER_GOOD_I,
    output reg                     CMD_READY_O,
    output reg                     DONE_O,
    output reg                     REFUSED_O,
    output reg  [`NVSC_DATA_W-1:0] RDATA_O,
    output reg                     SELECT_N_O,
    output reg                     WRITE_N_O,
    output reg                     RESTORE_N_O,
    output reg                     SAVE_N_O,
    output reg  [`NVSC_ADDR_W-1:0] WORD_ADDRESS_O,
    output reg  [`NVSC_DATA_W-1:0] DATA_PINS_O,
    output reg                     DATA_PINS_OE_N_O,
    input  wire [`NVSC_DATA_W-1:0] DATA_PINS_I
);
    // --------------------------------------------------------------
    // states
    // --------------------------------------------------------------
    localparam [7:0] ST_IDLE  = 8'h01;
    localparam [7:0] ST_WSET  = 8'h02;
    localparam [7:0] ST_WPUL  = 8'h04;
    localparam [7:0] ST_RACC  = 8'h08;
    localparam [7:0] ST_RPUL  = 8'h10;
    localparam [7:0] ST_SPUL  = 8'h20;
    localparam [7:0] ST_WAIT  = 8'h40;
    localparam [7:0] ST_REC   = 8'h80;

    // cycle counts as integers, cut to the counter width below
    localparam integer N_SETUP  = `NVSC_CYC_SETUP;
    localparam integer N_WPULSE = `NVSC_CYC_WPULSE;
    localparam integer N_WREC   = `NVSC_CYC_WREC;
    localparam integer N_RACC   = `NVSC_CYC_RACCESS;
    localparam integer N_ODIS   = `NVSC_CYC_ODIS;
    localparam integer N_RCYCLE = `NVSC_CYC_RCYCLE;
    localparam integer N_RFIRST = `NVSC_CYC_RFIRST;
    localparam integer N_SPULSE = `NVSC_CYC_SPULSE;
    localparam integer N_SCYCLE = SAVE_CYCLES;

    localparam [`NVSC_CNT_W-1:0] C_SETUP  = N_SETUP[`NVSC_CNT_W-1:0];
    localparam [`NVSC_CNT_W-1:0] C_WPULSE = N_WPULSE[`NVSC_CNT_W-1:0];
    localparam [`NVSC_CNT_W-1:0] C_WREC   = N_WREC[`NVSC_CNT_W-1:0];
    localparam [`NVSC_CNT_W-1:0] C_RACC   = N_RACC[`NVSC_CNT_W-1:0];
    localparam [`NVSC_CNT_W-1:0] C_ODIS   = N_ODIS[`NVSC_CNT_W-1:0];
    localparam [`NVSC_CNT_W-1:0] C_RCYCLE = N_RCYCLE[`NVSC_CNT_W-1:0];
    localparam [`NVSC_CNT_W-1:0] C_RFIRST = N_RFIRST[`NVSC_CNT_W-1:0];
    localparam [`NVSC_CNT_W-1:0] C_SPULSE = N_SPULSE[`NVSC_CNT_W-1:0];
    localparam [`NVSC_CNT_W-1:0] C_SCYCLE = N_SCYCLE[`NVSC_CNT_W-1:0];
    localparam [`NVSC_CNT_W-1:0] C_ONE    = {{(`NVSC_CNT_W-1){1'b0}}, 1'b1};

    // a phase ends when its counter reaches its last cycle
    function cnt_last;
        input [`NVSC_CNT_W-1:0] cnt;
        begin
            cnt_last = (cnt <= C_ONE);
        end
    endfunction

    // --------------------------------------------------------------
    // synchronised pin inputs
    // --------------------------------------------------------------
    wire [`NVSC_DATA_W-1:0] rdata_s;
    wire                    pgood_s;

    nvsc_sync #(
        .W (`NVSC_DATA_W + 1)
    ) u_sync (
        .clk_i (SYS_CLK_I),
        .rst_i (RESET_I),
        .d_i   ({POWER_GOOD_I, DATA_PINS_I}),
        .q_o   ({pgood_s, rdata_s})
    );

    reg [7:0]              state_q;
    reg [`NVSC_CNT_W-1:0]  cnt_q;

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_q          <= ST_IDLE;
            cnt_q            <= {`NVSC_CNT_W{1'b0}};
            CMD_READY_O      <= 1'b0;
            DONE_O           <= 1'b0;
            REFUSED_O        <= 1'b0;
            RDATA_O          <= {`NVSC_DATA_W{1'b0}};
            SELECT_N_O       <= 1'b1;
            WRITE_N_O        <= 1'b1;
            RESTORE_N_O      <= 1'b1;
            SAVE_N_O         <= 1'b1;
            WORD_ADDRESS_O   <= {`NVSC_ADDR_W{1'b0}};
            DATA_PINS_O      <= {`NVSC_DATA_W{1'b0}};
            DATA_PINS_OE_N_O <= 1'b1;
        end else begin
            DONE_O    <= 1'b0;
            REFUSED_O <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    CMD_READY_O <= 1'b1;
                    if (CMD_VALID_I && CMD_READY_O) begin
                        CMD_READY_O    <= 1'b0;
                        WORD_ADDRESS_O <= CMD_ADDR_I;
                        case (CMD_OP_I)
                            `NVSC_CMD_WRITE: begin
                                WRITE_N_O   <= 1'b0;
                                DATA_PINS_O <= CMD_WDATA_I;
                                cnt_q       <= C_SETUP;
                                state_q     <= ST_WSET;
                            end
                            `NVSC_CMD_RESTORE: begin
                                RESTORE_N_O <= 1'b0;
                                SELECT_N_O  <= 1'b1;
                                cnt_q       <= C_RCYCLE;
                                state_q     <= ST_RPUL;
                            end
                            `NVSC_CMD_SAVE: begin
                                if (!pgood_s) begin
                                    REFUSED_O   <= 1'b1;
                                    DONE_O      <= 1'b1;
                                    CMD_READY_O <= 1'b1;
                                end else begin
                                    SAVE_N_O   <= 1'b0;
                                    SELECT_N_O <= 1'b1;
                                    cnt_q      <= C_SPULSE;
                                    state_q    <= ST_SPUL;
                                end
                            end
                            default: begin
                                SELECT_N_O <= 1'b0;
                                cnt_q      <= C_RACC;
                                state_q    <= ST_RACC;
                            end
                        endcase
                    end
                end
                ST_WSET: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_last(cnt_q)) begin
                        SELECT_N_O       <= 1'b0;
                        DATA_PINS_OE_N_O <= 1'b0;
                        cnt_q            <= C_WPULSE;
                        state_q          <= ST_WPUL;
                    end
                end
                ST_WPUL: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_last(cnt_q)) begin
                        WRITE_N_O  <= 1'b1;
                        SELECT_N_O <= 1'b1;
                        cnt_q      <= C_WREC;
                        state_q    <= ST_REC;
                    end
                end
                ST_RACC: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_last(cnt_q)) begin
                        RDATA_O    <= rdata_s;
                        SELECT_N_O <= 1'b1;
                        cnt_q      <= C_ODIS;
                        state_q    <= ST_REC;
                    end
                end
                ST_RPUL: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_last(cnt_q)) begin
                        RESTORE_N_O <= 1'b1;
                        cnt_q       <= C_ODIS;
                        state_q     <= ST_REC;
                    end
                end
                ST_SPUL: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_last(cnt_q)) begin
                        SAVE_N_O <= 1'b1;
                        cnt_q    <= C_SCYCLE;
                        state_q  <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_last(cnt_q)) begin
                        state_q <= ST_REC;
                        cnt_q   <= C_ODIS;
                    end
                end
                ST_REC: begin
                    DATA_PINS_OE_N_O <= 1'b1;
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_last(cnt_q)) begin
                        DONE_O      <= 1'b1;
                        CMD_READY_O <= 1'b1;
                        state_q     <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- verif/nvsc_host_sva.sv ----
// Purpose: pin protocol checks for the shadowed memory host
// Assumes: one clock, asynchronous active high reset
// Notes:   helper counters hold strobe low widths in cycles
`timescale 1ns/100ps
`include "nvsc_defs.vh"
module nvsc_host_sva #(
    parameter SAVE_CYCLES = 50
) (
    input wire                    SYS_CLK_I,
    input wire                    RESET_I,
    input wire                    CMD_READY_O,
    input wire                    POWER_GOOD_I,
    input wire                    SELECT_N_O,
    input wire                    WRITE_N_O,
    input wire                    RESTORE_N_O,
    input wire                    SAVE_N_O,
    input wire                    DATA_PINS_OE_N_O,
    input wire [`NVSC_ADDR_W-1:0] WORD_ADDRESS_O
);
    // ------------------------------------------------
    // strobe width counters and pin checks
    // ------------------------------------------------
    reg [7:0] rl_q;
    reg [7:0] sl_q;
    reg [7:0] wl_q;
    always @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rl_q <= 8'h00;
            sl_q <= 8'h00;
            wl_q <= 8'h00;
        end else begin
            rl_q <= RESTORE_N_O ? 8'h00 : rl_q + {7'h00, ~&rl_q};
            sl_q <= SAVE_N_O ? 8'h00 : sl_q + {7'h00, ~&sl_q};
            // write width counts only the overlap of strobe and select
            wl_q <= (WRITE_N_O | SELECT_N_O) ? 8'h00 : wl_q + {7'h00, ~&wl_q};
        end
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    idle_quiet_a: assert property (CMD_READY_O |-> SELECT_N_O && WRITE_N_O && RESTORE_N_O && SAVE_N_O)
        else $error("strobe low while idle");
    xfer_excl_a: assert property (!(!RESTORE_N_O && !SAVE_N_O))
        else $error("restore and save low together");
    rest_hiz_a: assert property (!RESTORE_N_O |-> DATA_PINS_OE_N_O)
        else $error("data driven during restore");
    save_hiz_a: assert property (!SAVE_N_O |-> DATA_PINS_OE_N_O && SELECT_N_O)
        else $error("data driven during save");
    rest_width_a: assert property ($rose(RESTORE_N_O) |-> rl_q >= 8'h8c)
        else $error("restore pulse too short");
    save_width_a: assert property ($rose(SAVE_N_O) |-> sl_q >= 8'h14)
        else $error("save pulse too short");
    save_power_a: assert property ($fell(SAVE_N_O) |-> $past(POWER_GOOD_I, 3))
        else $error("save started on low supply");
    wr_setup_a: assert property ($fell(DATA_PINS_OE_N_O) |-> !$past(WRITE_N_O, 5) && $stable(WORD_ADDRESS_O))
        else $error("write data before address setup");
    wr_width_a: assert property ($rose(WRITE_N_O) |-> wl_q >= 8'h0f)
        else $error("write pulse too short");
endmodule

// ---- verif/nvsc_dev_model.sv ----
// Purpose: behavioural model of the shadowed 64 x 4 memory
// Assumes: pins are asynchronous; times in ns
// Notes:   released data pins show a wandering pattern
`timescale 1ns/100ps
module nvsc_dev_model #(
    parameter RD_NS   = 200,
    parameter SAVE_NS = 400
) (
    input  wire       select_n_i,
    input  wire       write_n_i,
    input  wire       restore_n_i,
    input  wire       save_n_i,
    input  wire       power_good_i,
    input  wire [5:0] addr_i,
    input  wire [3:0] host_data_i,
    input  wire       host_oe_n_i,
    output wire [3:0] bus_o
);
    // ------------------------------------------------
    // arrays and transfers
    // ------------------------------------------------
    reg  [3:0] ram [0:63];
    reg  [3:0] nv  [0:63];
    reg        rest_busy = 1'b0;
    reg        save_busy = 1'b0;
    reg        rd_ok     = 1'b0;
    reg  [3:0] junk      = 4'h0;
    integer    i;
    integer    j;
    integer    k;
    wire       idle   = restore_n_i & save_n_i & ~rest_busy & ~save_busy;
    wire       rd_act = ~select_n_i & write_n_i & idle;
    wire       wr_act = ~select_n_i & ~write_n_i & idle;
    always #7 junk = junk + 4'h5;
    assign bus_o = ~host_oe_n_i ? host_data_i : (rd_ok ? ram[addr_i] : junk);
    always @(posedge rd_act) begin
        rd_ok = 1'b0;
        #(RD_NS) rd_ok = rd_act;
    end
    always @(negedge rd_act) rd_ok = 1'b0;
    always @(negedge wr_act) ram[addr_i] = bus_o;
    always @(negedge restore_n_i) if (!save_busy) begin
        rest_busy = 1'b1;
        for (i = 0; i < 64; i = i + 1) ram[i] = nv[i];
        #1400;
        for (k = 0; k < 1000 && !restore_n_i; k = k + 1) #10;
        rest_busy = 1'b0;
    end
    always @(negedge save_n_i) if (restore_n_i && !rest_busy && power_good_i) begin
        save_busy = 1'b1;
        for (j = 0; j < 64; j = j + 1) nv[j] = ram[j];
        #(SAVE_NS) save_busy = 1'b0;
    end
endmodule

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench for the shadowed memory host
// Assumes: 100 MHz clock, short save time in simulation
// Notes:   restore expectations come from preset array contents, the others from written data
`timescale 1ns/100ps
module tb_top;
    // ------------------------------------------------
    // stimulus, instances and scenarios
    // ------------------------------------------------
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg        vld = 1'b0;
    reg        pg  = 1'b1;
    reg  [1:0] op  = 2'h0;
    reg  [5:0] adr = 6'h00;
    reg  [3:0] wd  = 4'h0;
    reg        ref_q;
    wire       rdy, done, refd, sel_n, wr_n, rec_n, sav_n, oe_n;
    wire [5:0] wa;
    wire [3:0] rdata, dout, pins;
    integer    errors   = 0;
    integer    n_checks = 0;
    integer    i;
    nvsc_host #(.SAVE_CYCLES(50)) u_dut (.SYS_CLK_I(clk), .RESET_I(rst), .CMD_VALID_I(vld), .CMD_OP_I(op),
        .CMD_ADDR_I(adr), .CMD_WDATA_I(wd), .POWER_GOOD_I(pg), .CMD_READY_O(rdy), .DONE_O(done), .REFUSED_O(refd),
        .RDATA_O(rdata), .SELECT_N_O(sel_n), .WRITE_N_O(wr_n), .RESTORE_N_O(rec_n), .SAVE_N_O(sav_n),
        .WORD_ADDRESS_O(wa), .DATA_PINS_O(dout), .DATA_PINS_OE_N_O(oe_n), .DATA_PINS_I(pins));
    nvsc_dev_model u_dev (.select_n_i(sel_n), .write_n_i(wr_n), .restore_n_i(rec_n), .save_n_i(sav_n),
        .power_good_i(pg), .addr_i(wa), .host_data_i(dout), .host_oe_n_i(oe_n), .bus_o(pins));
    initial forever #5 clk = ~clk;
    task end_sim;
        begin
            $display("errors=%0d checks=%0d", errors, n_checks);
            if (errors == 0 && n_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [3:0] got, input [3:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
                errors = errors + 1;
            end
        end
    endtask
    task cmd(input [1:0] o, input [5:0] a, input [3:0] d);
        integer n;
        begin
            @(posedge clk);
            {op, adr, wd, vld} <= {o, a, d, 1'b1};
            @(posedge clk);
            vld <= 1'b0;
            #1;
            for (n = 0; n < 400 && done !== 1'b1; n = n + 1) @(posedge clk) #1;
            ref_q = refd;
            if (n == 400) begin
                errors = errors + 1;
                end_sim;
            end
        end
    endtask
    task s_write_read;
        begin
            cmd(2'h1, 6'h00, 4'h5);
            cmd(2'h1, 6'h3f, 4'ha);
            chk(u_dev.ram[63], 4'ha);
            cmd(2'h0, 6'h00, 4'h0);
            chk(rdata, 4'h5);
            cmd(2'h0, 6'h3f, 4'h0);
            chk(rdata, 4'ha);
        end
    endtask
    task s_restore;
        begin
            cmd(2'h1, 6'h10, 4'h0);
            cmd(2'h2, 6'h00, 4'h0);
            chk({3'h0, ref_q}, 4'h0);
            cmd(2'h0, 6'h10, 4'h0);
            chk(rdata, 4'h9);
            cmd(2'h0, 6'h2a, 4'h0);
            chk(rdata, 4'h3);
        end
    endtask
    task s_save(input pwr, input [3:0] d, input [3:0] nv_exp);
        begin
            @(posedge clk);
            pg <= pwr;
            cmd(2'h1, 6'h07, d);
            cmd(2'h3, 6'h00, 4'h0);
            chk({3'h0, ref_q}, {3'h0, ~pwr});
            chk(u_dev.nv[7], nv_exp);
            cmd(2'h0, 6'h07, 4'h0);
            chk(rdata, d);
        end
    endtask
    initial begin
        for (i = 0; i < 64; i = i + 1) u_dev.nv[i] = i[3:0] ^ 4'h9;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({sel_n, wr_n, rec_n, sav_n}, 4'hf);
        s_write_read;
        s_restore;
        s_save(1'b1, 4'hc, 4'hc);
        s_save(1'b0, 4'h3, 4'hc);
        end_sim;
    end
endmodule
bind nvsc_host nvsc_host_sva #(.SAVE_CYCLES(SAVE_CYCLES)) u_sva (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
    .CMD_READY_O(CMD_READY_O), .POWER_GOOD_I(POWER_GOOD_I), .SELECT_N_O(SELECT_N_O), .WRITE_N_O(WRITE_N_O),
    .RESTORE_N_O(RESTORE_N_O), .SAVE_N_O(SAVE_N_O), .DATA_PINS_OE_N_O(DATA_PINS_OE_N_O),
    .WORD_ADDRESS_O(WORD_ADDRESS_O));
